// ===== rail_seq_pkg.sv
// Shared constants, types and helper functions for the rail sequencer and trimmer.
`default_nettype none
package rail_seq_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_RAILS = 4;
  localparam int CFG_ADDR_W = 6;
  localparam int CFG_DEPTH = 64;
  localparam int SLOT_W = 3;
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST = 3'h7;

  // ---------------------------------------------------------------
  // Configuration table layout: address = {rail, field offset}
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_SLOT = 4'h0;
  localparam logic [3:0] OFS_ON_DELAY = 4'h1;
  localparam logic [3:0] OFS_OFF_DELAY = 4'h2;
  localparam logic [3:0] OFS_TRIM_MODE = 4'h3;
  localparam logic [3:0] OFS_TRIM_PIN = 4'h4;
  localparam logic [3:0] OFS_TRIM_HIGH = 4'h5;
  localparam logic [3:0] OFS_TRIM_LOW = 4'h6;
  localparam logic [3:0] OFS_NOMINAL = 4'h7;
  localparam logic [3:0] OFS_MARGIN_HIGH = 4'h8;
  localparam logic [3:0] OFS_MARGIN_LOW = 4'h9;
  localparam logic [3:0] OFS_LOW_THR = 4'ha;
  localparam logic [3:0] OFS_OFF_THR = 4'hb;

  // ---------------------------------------------------------------
  // Trim modes and DAC limits
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_OPEN = 2'h1;
  localparam logic [1:0] MODE_CLOSED = 2'h2;
  localparam logic [7:0] TRIM_MIN = 8'h00;
  localparam logic [7:0] TRIM_MAX = 8'hff;
  localparam logic [7:0] TRIM_STEP = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Timing: delays count in ticks of one millisecond.
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_OFF = 3'b001,
    ST_UP_ENTER = 3'b010,
    ST_UP_RUN = 3'b011,
    ST_ON = 3'b100,
    ST_DOWN_ENTER = 3'b101,
    ST_DOWN_RUN = 3'b110
  } seq_state_t;

  // Returns the first of three values that is nonzero, else the last.
  function automatic logic [7:0] first_nonzero(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    first_nonzero = (a != BYTE_ZERO) ? a : ((b != BYTE_ZERO) ? b : c);
  endfunction

endpackage
`default_nettype wire

// ===== rail_delay_timer.sv
// Per-rail delay timer counting whole ticks after a load.
`timescale 1ns/10ps
`default_nettype none
module rail_delay_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] delay,
  input wire logic tick,
  output logic expired
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic next_expired;

  always_comb begin
    next_count = count;
    next_expired = expired;
    if (load) begin
      next_count = delay;
      next_expired = 1'b0;
    end else if (!expired) begin
      if (count == rail_seq_pkg::BYTE_ZERO) begin
        next_expired = 1'b1;
      end else if (tick) begin
        next_count = count - rail_seq_pkg::TRIM_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      expired <= 1'b1;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

endmodule
`default_nettype wire

// ===== trim_pwm_dac.sv
// Pulse-width DAC driving one trim pin through an external low-pass filter.
`timescale 1ns/10ps
`default_nettype none
module trim_pwm_dac (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [7:0] duty,
  output logic pwm
);

  logic [7:0] phase;
  logic [7:0] next_phase;
  logic next_pwm;

  always_comb begin
    next_phase = phase + rail_seq_pkg::TRIM_STEP;
    next_pwm = active && (phase < duty);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 8'h00;
      pwm <= 1'b0;
    end else begin
      phase <= next_phase;
      pwm <= next_pwm;
    end
  end

endmodule
`default_nettype wire

// ===== rail_sequencer_trimmer.sv
// Rail power sequencer with per-rail pulse-width trimming.
// What this block does
// R1: Enable rails in turn up, disable in turn down.
// R2: Regulator enable outputs are active high.
// R3: Disabled enables are driven low, never high.
// R4: Rails sit in ordered numbered slots or none.
// R5: Per-rail delay before switching in active slot.
// R6: On delay applies only to power-up.
// R7: Next up slot after all exceed first threshold.
// R8: Next down slot after all reach off level.
// R9: Open-loop or closed-loop trim chosen per rail.
// R10: Trim value leaves as a PWM signal.
// R11: Open-loop trim set once at initialization.
// R12: Closed-loop rails measured and adjusted each pass.
// R13: Above target adds one, below subtracts one.
// R14: Parameters come from a byte-wide configuration store.
// R15: Initial trim: pin value, else high, else low.
// R16: Target: nominal, else margin high, else low.
// R17: Closed-loop steps start after power-up completes.
// R18: Off delay applies only to power-down.
// R19: Closed-loop trim saturates at DAC limits.
// R20: Trim mode none gives no trim output.
`timescale 1ns/10ps
`default_nettype none
module rail_sequencer_trimmer #(
  parameter int TICK_CYCLES = rail_seq_pkg::TICK_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CFG_WRITE,
  input wire logic [5:0] CFG_ADDR,
  input wire logic [7:0] CFG_DATA,
  input wire logic CFG_VALID,
  input wire logic POWER_UP_REQ,
  input wire logic [7:0] RAIL1_VOLTAGE,
  input wire logic [7:0] RAIL2_VOLTAGE,
  input wire logic [7:0] RAIL3_VOLTAGE,
  input wire logic [7:0] RAIL4_VOLTAGE,
  output logic RAIL1_ENABLE_OUT,
  output logic RAIL2_ENABLE_OUT,
  output logic RAIL3_ENABLE_OUT,
  output logic RAIL4_ENABLE_OUT,
  output logic RAIL1_TRIM_PWM,
  output logic RAIL2_TRIM_PWM,
  output logic RAIL3_TRIM_PWM,
  output logic RAIL4_TRIM_PWM,
  output logic POWERED_UP,
  output logic SEQ_BUSY
);

  localparam int NR = rail_seq_pkg::NUM_RAILS;

  // ---------------------------------------------------------------
  // Reset release synchroniser
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Configuration store
  // ---------------------------------------------------------------
  logic [7:0] cfg_mem [0:rail_seq_pkg::CFG_DEPTH-1];

  // The table has no reset so that a loaded image survives a controller reset.
  always_ff @(posedge MCLK) begin
    if (CFG_WRITE) begin
      cfg_mem[CFG_ADDR] <= CFG_DATA; // [R14]
    end
  end

  function automatic logic [7:0] cfg_field(input int rail, input logic [3:0] ofs);
    logic [5:0] addr;
    addr = {rail[1:0], ofs};
    cfg_field = cfg_mem[addr];
  endfunction

  // ---------------------------------------------------------------
  // Tick generator: one pulse per delay unit and per scan pass
  // ---------------------------------------------------------------
  logic [15:0] tick_count;
  logic [15:0] next_tick_count;
  logic tick;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_tick_count = tick_count + 16'h0001;
    if (tick_count == 16'(TICK_CYCLES - 1)) begin
      next_tick_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      tick <= next_tick;
    end
  end

  // ---------------------------------------------------------------
  // Per-rail views of inputs and configuration
  // ---------------------------------------------------------------
  logic [7:0] volt [0:NR-1];
  logic [2:0] rail_slot [0:NR-1];
  logic [1:0] rail_mode [0:NR-1];
  logic [7:0] target [0:NR-1];

  assign volt[0] = RAIL1_VOLTAGE;
  assign volt[1] = RAIL2_VOLTAGE;
  assign volt[2] = RAIL3_VOLTAGE;
  assign volt[3] = RAIL4_VOLTAGE;

  always_comb begin
    for (int i = 0; i < NR; i++) begin
      rail_slot[i] = 3'(cfg_field(i, rail_seq_pkg::OFS_SLOT)); // [R4]
      rail_mode[i] = 2'(cfg_field(i, rail_seq_pkg::OFS_TRIM_MODE)); // [R9]
      target[i] = rail_seq_pkg::first_nonzero(cfg_field(i, rail_seq_pkg::OFS_NOMINAL),
                                              cfg_field(i, rail_seq_pkg::OFS_MARGIN_HIGH),
                                              cfg_field(i, rail_seq_pkg::OFS_MARGIN_LOW)); // [R16]
    end
  end

  // ---------------------------------------------------------------
  // Delay timers
  // ---------------------------------------------------------------
  logic [NR-1:0] timer_load;
  logic [NR-1:0] timer_expired;
  logic [7:0] timer_delay [0:NR-1];

  for (genvar g = 0; g < NR; g++) begin : g_timer
    rail_delay_timer u_timer (
      .clk(MCLK),
      .rst_n(rst_n),
      .load(timer_load[g]),
      .delay(timer_delay[g]),
      .tick(tick),
      .expired(timer_expired[g])
    );
  end

  // ---------------------------------------------------------------
  // Sequencer and trim state
  // ---------------------------------------------------------------
  rail_seq_pkg::seq_state_t state;
  rail_seq_pkg::seq_state_t next_state;
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic [NR-1:0] enable;
  logic [NR-1:0] next_enable;
  logic [7:0] trim [0:NR-1];
  logic [7:0] next_trim [0:NR-1];
  logic next_powered_up;
  logic next_seq_busy;

  always_comb begin
    logic slot_done;
    logic in_slot;
    slot_done = 1'b1;
    in_slot = 1'b0;
    next_state = state;
    next_slot = slot;
    next_enable = enable;
    timer_load = '0;
    for (int i = 0; i < NR; i++) begin
      next_trim[i] = trim[i];
      timer_delay[i] = cfg_field(i, rail_seq_pkg::OFS_ON_DELAY); // [R6]
      if (state == rail_seq_pkg::ST_DOWN_ENTER || state == rail_seq_pkg::ST_DOWN_RUN) begin
        timer_delay[i] = cfg_field(i, rail_seq_pkg::OFS_OFF_DELAY); // [R18]
      end
    end
    case (state)
      rail_seq_pkg::ST_INIT: begin
        next_enable = '0; // [R3]
        if (CFG_VALID) begin
          for (int i = 0; i < NR; i++) begin
            next_trim[i] = rail_seq_pkg::first_nonzero(cfg_field(i, rail_seq_pkg::OFS_TRIM_PIN),
                                                       cfg_field(i, rail_seq_pkg::OFS_TRIM_HIGH),
                                                       cfg_field(i, rail_seq_pkg::OFS_TRIM_LOW)); // [R15] [R11]
          end
          next_state = rail_seq_pkg::ST_OFF;
        end
      end
      rail_seq_pkg::ST_OFF: begin
        if (POWER_UP_REQ) begin
          next_slot = rail_seq_pkg::SLOT_FIRST;
          next_state = rail_seq_pkg::ST_UP_ENTER;
        end
      end
      rail_seq_pkg::ST_UP_ENTER, rail_seq_pkg::ST_DOWN_ENTER: begin
        for (int i = 0; i < NR; i++) begin
          timer_load[i] = (rail_slot[i] == slot); // [R5]
        end
        next_state = (state == rail_seq_pkg::ST_UP_ENTER) ? rail_seq_pkg::ST_UP_RUN : rail_seq_pkg::ST_DOWN_RUN;
      end
      rail_seq_pkg::ST_UP_RUN: begin
        for (int i = 0; i < NR; i++) begin
          in_slot = (rail_slot[i] == slot) && (slot != rail_seq_pkg::SLOT_NONE);
          if (in_slot) begin
            if (timer_expired[i]) begin
              next_enable[i] = 1'b1; // [R1] [R2]
            end
            if (!enable[i] || volt[i] <= cfg_field(i, rail_seq_pkg::OFS_LOW_THR)) begin
              slot_done = 1'b0; // [R7]
            end
          end
        end
        if (!POWER_UP_REQ) begin
          next_slot = rail_seq_pkg::SLOT_LAST;
          next_state = rail_seq_pkg::ST_DOWN_ENTER;
        end else if (slot_done) begin
          if (slot == rail_seq_pkg::SLOT_LAST) begin
            next_state = rail_seq_pkg::ST_ON;
          end else begin
            next_slot = slot + rail_seq_pkg::SLOT_FIRST; // [R4]
            next_state = rail_seq_pkg::ST_UP_ENTER;
          end
        end
      end
      rail_seq_pkg::ST_ON: begin
        for (int i = 0; i < NR; i++) begin
          if (tick && rail_mode[i] == rail_seq_pkg::MODE_CLOSED) begin // [R12] [R17] [R20]
            if (volt[i] > target[i] && trim[i] != rail_seq_pkg::TRIM_MAX) begin
              next_trim[i] = trim[i] + rail_seq_pkg::TRIM_STEP; // [R13] [R19]
            end else if (volt[i] < target[i] && trim[i] != rail_seq_pkg::TRIM_MIN) begin
              next_trim[i] = trim[i] - rail_seq_pkg::TRIM_STEP; // [R13] [R19]
            end
          end
        end
        if (!POWER_UP_REQ) begin
          next_slot = rail_seq_pkg::SLOT_LAST;
          next_state = rail_seq_pkg::ST_DOWN_ENTER;
        end
      end
      rail_seq_pkg::ST_DOWN_RUN: begin
        for (int i = 0; i < NR; i++) begin
          in_slot = (rail_slot[i] == slot) && (slot != rail_seq_pkg::SLOT_NONE);
          if (in_slot) begin
            if (timer_expired[i]) begin
              next_enable[i] = 1'b0; // [R1] [R3]
            end
            if (enable[i] || volt[i] > cfg_field(i, rail_seq_pkg::OFS_OFF_THR)) begin
              slot_done = 1'b0; // [R8]
            end
          end
        end
        if (slot_done) begin
          if (slot == rail_seq_pkg::SLOT_FIRST) begin
            next_state = rail_seq_pkg::ST_OFF;
          end else begin
            next_slot = slot - rail_seq_pkg::SLOT_FIRST;
            next_state = rail_seq_pkg::ST_DOWN_ENTER;
          end
        end
      end
      default: begin
        next_state = rail_seq_pkg::ST_INIT;
        next_enable = '0;
      end
    endcase
    next_powered_up = (next_state == rail_seq_pkg::ST_ON);
    next_seq_busy = (next_state != rail_seq_pkg::ST_ON) && (next_state != rail_seq_pkg::ST_OFF) &&
                    (next_state != rail_seq_pkg::ST_INIT);
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= rail_seq_pkg::ST_INIT;
      slot <= rail_seq_pkg::SLOT_NONE;
      enable <= '0;
      POWERED_UP <= 1'b0;
      SEQ_BUSY <= 1'b0;
      for (int i = 0; i < NR; i++) begin
        trim[i] <= rail_seq_pkg::TRIM_MIN;
      end
    end else begin
      state <= next_state;
      slot <= next_slot;
      enable <= next_enable;
      POWERED_UP <= next_powered_up;
      SEQ_BUSY <= next_seq_busy;
      for (int i = 0; i < NR; i++) begin
        trim[i] <= next_trim[i];
      end
    end
  end

  // Enable outputs are plain push-pull lows when off, so a grounded line is never fought.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RAIL1_ENABLE_OUT <= 1'b0;
      RAIL2_ENABLE_OUT <= 1'b0;
      RAIL3_ENABLE_OUT <= 1'b0;
      RAIL4_ENABLE_OUT <= 1'b0;
    end else begin
      RAIL1_ENABLE_OUT <= next_enable[0]; // [R2] [R3]
      RAIL2_ENABLE_OUT <= next_enable[1];
      RAIL3_ENABLE_OUT <= next_enable[2];
      RAIL4_ENABLE_OUT <= next_enable[3];
    end
  end

  // ---------------------------------------------------------------
  // Trim DACs
  // ---------------------------------------------------------------
  logic [NR-1:0] dac_active;
  logic [NR-1:0] pwm;

  for (genvar g = 0; g < NR; g++) begin : g_dac
    assign dac_active[g] = (state != rail_seq_pkg::ST_INIT) && (rail_mode[g] != rail_seq_pkg::MODE_NONE); // [R20]
    trim_pwm_dac u_dac (
      .clk(MCLK),
      .rst_n(rst_n),
      .active(dac_active[g]),
      .duty(trim[g]),
      .pwm(pwm[g]) // [R10]
    );
  end

  assign RAIL1_TRIM_PWM = pwm[0];
  assign RAIL2_TRIM_PWM = pwm[1];
  assign RAIL3_TRIM_PWM = pwm[2];
  assign RAIL4_TRIM_PWM = pwm[3];

endmodule
`default_nettype wire

// ===== rail_sequencer_trimmer_assertions.sv
// Port-level checks for the rail sequencer and trimmer.
`timescale 1ns/10ps
`default_nettype none
module rail_seq_checker (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CFG_VALID,
  input wire logic POWER_UP_REQ,
  input wire logic RAIL1_ENABLE_OUT,
  input wire logic RAIL2_ENABLE_OUT,
  input wire logic RAIL3_ENABLE_OUT,
  input wire logic RAIL4_ENABLE_OUT,
  input wire logic POWERED_UP,
  input wire logic SEQ_BUSY
);
  // ---------------------------------------------------------------
  // Sequencing relations
  // ---------------------------------------------------------------
  wire logic [3:0] en;
  assign en = {RAIL4_ENABLE_OUT, RAIL3_ENABLE_OUT, RAIL2_ENABLE_OUT, RAIL1_ENABLE_OUT};
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  a_done_not_busy: assert property (POWERED_UP |-> !SEQ_BUSY)
    else $error("powered up while still sequencing");
  a_on_enables_hold: assert property (POWERED_UP && $past(POWERED_UP) |-> $stable(en))
    else $error("enable changed while powered up");
  a_idle_enables_hold: assert property (!SEQ_BUSY && !POWERED_UP && !$past(SEQ_BUSY) && !$past(POWERED_UP)
    |-> $stable(en))
    else $error("enable changed while idle");
  a_rise_in_seq: assert property (|(en & ~$past(en)) |-> $past(SEQ_BUSY))
    else $error("enable rose outside a sequence");
  a_fall_in_seq: assert property (|(~en & $past(en)) |-> $past(SEQ_BUSY))
    else $error("enable fell outside a sequence");
  a_drop_leaves_on: assert property (POWERED_UP && !POWER_UP_REQ |-> ##[1:3] !POWERED_UP)
    else $error("power-down request not taken");
  a_req_starts_up: assert property (CFG_VALID && POWER_UP_REQ && !SEQ_BUSY && !POWERED_UP
    |-> ##[1:8] (SEQ_BUSY || POWERED_UP))
    else $error("power-up request not taken");
  a_busy_ends_clean: assert property ($fell(SEQ_BUSY) |-> ##[0:1] (POWERED_UP || en == 4'h0))
    else $error("sequence ended in a mixed state");
endmodule
bind rail_sequencer_trimmer rail_seq_checker u_chk (
  .MCLK(MCLK),
  .RESET_N(RESET_N),
  .CFG_VALID(CFG_VALID),
  .POWER_UP_REQ(POWER_UP_REQ),
  .RAIL1_ENABLE_OUT(RAIL1_ENABLE_OUT),
  .RAIL2_ENABLE_OUT(RAIL2_ENABLE_OUT),
  .RAIL3_ENABLE_OUT(RAIL3_ENABLE_OUT),
  .RAIL4_ENABLE_OUT(RAIL4_ENABLE_OUT),
  .POWERED_UP(POWERED_UP),
  .SEQ_BUSY(SEQ_BUSY)
);
`default_nettype wire

// ===== rail_regulator_model.sv
// Behavioural model of four regulators and their voltage monitors.
`timescale 1ns/10ps
`default_nettype none
module rail_regulator_model (
  input wire logic clk,
  input wire logic [3:0] enable,
  input wire logic [7:0] level [4],
  output logic [7:0] voltage [4]
);
  // ---------------------------------------------------------------
  // Ramp model
  // ---------------------------------------------------------------
  logic [1:0] cnt [4] = '{default: 2'h0};
  initial voltage = '{default: 8'h00};
  // A rail passes a mid level for a few cycles when it turns on or off.
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (enable[i] === 1'b1) begin
        if (cnt[i] != 2'h3) cnt[i] <= cnt[i] + 2'h1;
        voltage[i] <= (cnt[i] == 2'h3) ? level[i] : 8'h20;
      end else begin
        if (cnt[i] != 2'h0) cnt[i] <= cnt[i] - 2'h1;
        voltage[i] <= (cnt[i] == 2'h0) ? 8'h00 : 8'h20;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_rail_sequencer_trimmer.sv
// Self-checking testbench for the rail sequencer and trimmer.
`timescale 1ns/10ps
`default_nettype none
module test_rail_sequencer_trimmer;
  // ---------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------
  logic MCLK, RESET_N, CFG_WRITE, CFG_VALID, POWER_UP_REQ;
  logic [5:0] CFG_ADDR;
  logic [7:0] CFG_DATA;
  logic [7:0] level [4];
  logic [7:0] volt [4];
  logic e1, e2, e3, e4, p1, p2, p3, p4, POWERED_UP, SEQ_BUSY;
  wire logic [3:0] en;
  wire logic [3:0] pwm;
  wire logic [5:0] obs;
  int num_errors = 0;
  int num_checks = 0;
  localparam logic [13:0] TBL [16] = '{14'h0001, 14'h0102, 14'h0301, 14'h0540, 14'h0610, 14'h1003,
    14'h1203, 14'h1302, 14'h1480, 14'h1860, 14'h1970, 14'h2003, 14'h2103, 14'h2433, 14'h3301, 14'h3620};
  assign en = {e4, e3, e2, e1};
  assign pwm = {p4, p3, p2, p1};
  assign obs = {SEQ_BUSY, POWERED_UP, en};
  rail_sequencer_trimmer #(.TICK_CYCLES(4)) dut (.MCLK(MCLK), .RESET_N(RESET_N), .CFG_WRITE(CFG_WRITE),
    .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA), .CFG_VALID(CFG_VALID), .POWER_UP_REQ(POWER_UP_REQ),
    .RAIL1_VOLTAGE(volt[0]), .RAIL2_VOLTAGE(volt[1]), .RAIL3_VOLTAGE(volt[2]), .RAIL4_VOLTAGE(volt[3]),
    .RAIL1_ENABLE_OUT(e1), .RAIL2_ENABLE_OUT(e2), .RAIL3_ENABLE_OUT(e3), .RAIL4_ENABLE_OUT(e4),
    .RAIL1_TRIM_PWM(p1), .RAIL2_TRIM_PWM(p2), .RAIL3_TRIM_PWM(p3), .RAIL4_TRIM_PWM(p4),
    .POWERED_UP(POWERED_UP), .SEQ_BUSY(SEQ_BUSY));
  rail_regulator_model partner (.clk(MCLK), .enable(en), .level(level), .voltage(volt));
  always #50 MCLK = ~MCLK;
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [5:0] a, input logic [7:0] d);
    CFG_WRITE <= 1'b1;
    CFG_ADDR <= a;
    CFG_DATA <= d;
    @(posedge MCLK);
  endtask
  // Counting high samples over one full period gives the duty code.
  task automatic duty(input int i, input logic [8:0] exp);
    logic [8:0] n;
    n = 9'h000;
    repeat (256) begin
      @(posedge MCLK);
      n = n + 9'(pwm[i]);
    end
    check(n, exp);
  endtask
  task automatic wait_bit(input int i, input logic v);
    int k;
    for (k = 0; k < 400 && obs[i] !== v; k++) @(posedge MCLK);
    if (k == 400) begin
      check(9'h000, 9'h001);
      final_report();
    end
  endtask
  initial begin
    MCLK = 1'b0;
    RESET_N = 1'b0;
    CFG_WRITE = 1'b0;
    CFG_ADDR = 6'h00;
    CFG_DATA = 8'h00;
    CFG_VALID = 1'b0;
    POWER_UP_REQ = 1'b0;
    level = '{default: 8'h70};
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    for (int a = 0; a < 64; a++) cfg(6'(a), (a % 16 == 10) ? 8'h50 : ((a % 16 == 11) ? 8'h10 : 8'h00));
    for (int t = 0; t < 16; t++) cfg(TBL[t][13:8], TBL[t][7:0]);
    CFG_WRITE <= 1'b0;
    CFG_VALID <= 1'b1;
    repeat (4) @(posedge MCLK);
    check(9'(obs), 9'h000);
    duty(0, 9'h040);
    duty(1, 9'h080);
    duty(2, 9'h000);
    duty(3, 9'h020);
    level[0] <= 8'h30;
    POWER_UP_REQ <= 1'b1;
    wait_bit(0, 1'b1);
    repeat (40) @(posedge MCLK);
    check(9'(obs), 9'h021);
    level[0] <= 8'h70;
    wait_bit(1, 1'b1);
    check(9'(en), 9'h003);
    wait_bit(2, 1'b1);
    wait_bit(4, 1'b1);
    check(9'(obs), 9'h017);
    repeat (700) @(posedge MCLK);
    duty(1, 9'h0ff);
    duty(0, 9'h040);
    level[1] <= 8'h58;
    repeat (1200) @(posedge MCLK);
    duty(1, 9'h000);
    POWER_UP_REQ <= 1'b0;
    wait_bit(2, 1'b0);
    check(9'(en), 9'h003);
    wait_bit(1, 1'b0);
    check(9'(en), 9'h001);
    wait_bit(5, 1'b0);
    check(9'(obs), 9'h000);
    POWER_UP_REQ <= 1'b1;
    wait_bit(0, 1'b1);
    POWER_UP_REQ <= 1'b0;
    wait_bit(5, 1'b0);
    check(9'(obs), 9'h000);
    RESET_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    check(9'(obs), 9'h000);
    RESET_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    duty(1, 9'h080);
    duty(0, 9'h040);
    final_report();
  end
endmodule
`default_nettype wire
